// ### logic/pfc_defs.svh
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH
// Operation
// - Pause sending and pause reaction enable separately per port, all eight classes.
// - Each queue's usage above its own watermark raises that class's congestion bit.
// - Frame sender keeps an 8-bit per-class congestion vector and acts on it.
// - A newly congested class on an idle port triggers one pause frame.
// - At half the advertised pause time, still congested, send again.
// - New congestion while timing sends early after the minimum refresh interval.
// - One refresh timer per port serves all eight classes.
// - One per-port pause quanta value serves every class of each class pause frame.
// - Every frame carries all classes with enable vector 0x00ff.
// - Pause time of a class disabled for flow control is sent as zero.
// - Each sent frame bumps the transmit pause frame counter unless kept elsewhere.
// - Received class pause frames load each pause time whose enable vector bit is set into its own counter.
// - Received pause counters count down at the port's current link speed.
// - A stop indication stands for each class whose pause counter is nonzero.
// - Stop indications are recorded and hold back the matching egress queues.
// - Egress hold-back needs no configuration of its own.
// - Received class pause frames count as unknown-opcode control frames.

`define PFC_NUM_PRIO 8
`define PFC_CLK_NS 40
`define PFC_QUANTUM_BITS 512
`define PFC_QUANTUM_TENTHS (`PFC_QUANTUM_BITS * 10)

`define PFC_OFF_CTRL 8'h00
`define PFC_OFF_PRIO_ENA 8'h04
`define PFC_OFF_PAUSE 8'h08
`define PFC_OFF_MIN_REF 8'h0c
`define PFC_OFF_WM_BASE 8'h10
`define PFC_OFF_STATUS 8'h30
`define PFC_OFF_TX_CNT 8'h34
`define PFC_OFF_RX_CNT 8'h38

`define PFC_CTRL_TX_ENA 0
`define PFC_CTRL_RX_ENA 1
`define PFC_CTRL_LOCAL 2
`define PFC_CTRL_SPD_LSB 4

`define PFC_RST_CTRL 8'h00
`define PFC_RST_PRIO_ENA 8'hff
`define PFC_RST_PAUSE 16'hffff
`define PFC_RST_MIN_REF 16'h0040
`define PFC_RST_WM 16'h0100

`define PFC_DA 48'h0180_c200_0001
`define PFC_ETYPE 16'h8808
`define PFC_OPCODE 16'h0101
`define PFC_ENA_VEC 16'h00ff
`define PFC_VEC_POS 6'h10
`define PFC_TIMES_POS 6'h12
`define PFC_TIMES_END 6'h22
`define PFC_PDU_LEN 6'h3c
`endif

// ### logic/pfc_pkg.sv
`include "pfc_defs.svh"
package pfc_pkg;
  typedef logic [15:0] pfc_quanta_t;
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [7:0] data;
  } pfc_byte_s;
  typedef enum logic [2:0] {PFC_SPD_10M, PFC_SPD_100M, PFC_SPD_1G, PFC_SPD_2G5, PFC_SPD_10G} pfc_speed_e;
  typedef enum {PFC_TG_IDLE, PFC_TG_WAIT, PFC_TG_RUN} pfc_tg_e;

  // Tenths of a bit time that pass in one core clock
  function automatic logic [13:0] pfc_rate_inc(input logic [2:0] spd);
    case (spd)
      PFC_SPD_10M: pfc_rate_inc = 14'(10 * `PFC_CLK_NS / 100);
      PFC_SPD_100M: pfc_rate_inc = 14'(100 * `PFC_CLK_NS / 100);
      PFC_SPD_1G: pfc_rate_inc = 14'(1000 * `PFC_CLK_NS / 100);
      PFC_SPD_2G5: pfc_rate_inc = 14'(2500 * `PFC_CLK_NS / 100);
      PFC_SPD_10G: pfc_rate_inc = 14'(10000 * `PFC_CLK_NS / 100);
      default: pfc_rate_inc = 14'h0000;
    endcase
  endfunction : pfc_rate_inc

  // First sixteen bytes of a class pause frame
  function automatic logic [7:0] pfc_hdr_byte(input logic [5:0] pos, input logic [47:0] sa);
    logic [127:0] hdr;
    logic [6:0] base;
    hdr = {`PFC_DA, sa, `PFC_ETYPE, `PFC_OPCODE};
    base = 7'(7'h7f - {pos[3:0], 3'b000});
    pfc_hdr_byte = (pos < 6'h10) ? hdr[base -: 8] : 8'h00;
  endfunction : pfc_hdr_byte
endpackage : pfc_pkg

// ### logic/pfc_tx_gen.sv
module pfc_tx_gen (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Configuration
  input wire logic tx_ena,
  input wire logic [7:0] prio_ena,
  input wire pfc_pkg::pfc_quanta_t pause_quanta,
  input wire pfc_pkg::pfc_quanta_t min_refresh,
  // Congestion and time base
  input wire logic [7:0] congestion_vector,
  input wire logic quanta_tick,
  // Frame sender handshake
  input wire logic pdu_sent,
  output logic send_req,
  output logic [7:0] send_vec
);
  pfc_pkg::pfc_tg_e state;
  logic [7:0] cong_eff;
  logic [7:0] adv;
  logic [15:0] half_left;
  logic [15:0] since_send;
  logic early;
  logic fire;

  assign cong_eff = congestion_vector & prio_ena & {8{tx_ena}};
  assign fire = (early && since_send >= min_refresh) || (half_left == 16'h0000 && cong_eff != 8'h00);

  // Single timer pair for the whole port
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= pfc_pkg::PFC_TG_IDLE;
      send_req <= 1'b0;
      send_vec <= 8'h00;
      adv <= 8'h00;
      half_left <= 16'h0000;
      since_send <= 16'h0000;
      early <= 1'b0;
    end else begin
      unique case (state)
        pfc_pkg::PFC_TG_IDLE: begin
          if (cong_eff != 8'h00) begin
            send_req <= 1'b1;
            send_vec <= cong_eff;
            state <= pfc_pkg::PFC_TG_WAIT;
          end
        end
        pfc_pkg::PFC_TG_WAIT: begin
          if (pdu_sent) begin
            send_req <= 1'b0;
            adv <= send_vec;
            half_left <= {1'b0, pause_quanta[15:1]};
            since_send <= 16'h0000;
            early <= 1'b0;
            state <= pfc_pkg::PFC_TG_RUN;
          end
        end
        pfc_pkg::PFC_TG_RUN: begin
          if (fire) begin
            send_req <= 1'b1;
            send_vec <= cong_eff;
            state <= pfc_pkg::PFC_TG_WAIT;
          end else if (half_left == 16'h0000) begin
            state <= pfc_pkg::PFC_TG_IDLE;
          end else begin
            if ((cong_eff & ~adv) != 8'h00) begin
              early <= 1'b1;
            end
            if (quanta_tick) begin
              half_left <= half_left - 16'h0001;
              if (since_send != 16'hffff) begin
                since_send <= since_send + 16'h0001;
              end
            end
          end
        end
      endcase
    end
  end

  chk_idle_send: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == pfc_pkg::PFC_TG_IDLE && cong_eff != 8'h00 |=> send_req && send_vec == $past(cong_eff))
    else $error("congestion on idle port did not request a frame");
  chk_half_resend: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == pfc_pkg::PFC_TG_RUN && half_left == 16'h0000 && cong_eff != 8'h00 |=> send_req)
    else $error("no refresh at half pause time");
endmodule : pfc_tx_gen

// ### logic/pfc_rx_pause.sv
`include "pfc_defs.svh"
module pfc_rx_pause (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Received pause values
  input wire logic load,
  input wire logic [7:0] load_vec,
  input wire logic [7:0][15:0] load_times,
  input wire logic quanta_tick,
  // Stop per class
  output logic [7:0] stop
);
  pfc_pkg::pfc_quanta_t cnt [`PFC_NUM_PRIO];

  // A new frame wins over the countdown, so a zero time resumes at once
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `PFC_NUM_PRIO; i++) begin
        cnt[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < `PFC_NUM_PRIO; i++) begin
        if (load && load_vec[i]) begin
          cnt[i] <= load_times[i];
        end else if (quanta_tick && cnt[i] != 16'h0000) begin
          cnt[i] <= cnt[i] - 16'h0001;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `PFC_NUM_PRIO; i++) begin
      stop[i] = cnt[i] != 16'h0000;
    end
  end

  chk_load_time: assert property (@(posedge sys_clk) disable iff (sys_rst)
    load && load_vec[0] |=> cnt[0] == $past(load_times[0]))
    else $error("received pause time not loaded");
endmodule : pfc_rx_pause

// ### logic/pfc_top.sv
// Decided for this implementation: the address-and-strobe port and the address map.
`include "pfc_defs.svh"
module pfc_top #(
  parameter int NUM_PRIO = `PFC_NUM_PRIO,
  parameter logic [47:0] SRC_MAC = 48'h0000_0000_0000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Queue system
  input wire logic [7:0][15:0] q_usage,
  input wire logic [7:0] egress_req,
  output logic [7:0] egress_allow,
  output logic [7:0] stop_vec,
  // Transmit byte stream
  output pfc_pkg::pfc_byte_s tx_out,
  input wire logic tx_ready,
  // Receive byte stream
  input wire pfc_pkg::pfc_byte_s rx_in
);
  localparam logic [15:0] ENA_VEC = `PFC_ENA_VEC;
  localparam logic [13:0] QUANTUM = 14'(`PFC_QUANTUM_TENTHS);

  if (NUM_PRIO != `PFC_NUM_PRIO) begin : g_bad_prio
    $error("pfc_top serves exactly eight classes");
  end
  if (SRC_MAC[40]) begin : g_bad_mac
    $error("pfc_top source address must be unicast");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl;
  logic [7:0] prio_ena;
  pfc_pkg::pfc_quanta_t tx_pause_quanta;
  pfc_pkg::pfc_quanta_t min_refresh_interval;
  pfc_pkg::pfc_quanta_t wm [`PFC_NUM_PRIO];
  logic [31:0] tx_pause_frame_count;
  logic [31:0] rx_unknown_opcode_count;
  logic [7:0] congestion_vector;
  logic tx_ena;
  logic rx_ena;
  logic local_stats;
  logic [2:0] speed;
  logic wm_hit;
  logic [2:0] wm_idx;

  assign tx_ena = ctrl[`PFC_CTRL_TX_ENA];
  assign rx_ena = ctrl[`PFC_CTRL_RX_ENA];
  assign local_stats = ctrl[`PFC_CTRL_LOCAL];
  assign speed = ctrl[`PFC_CTRL_SPD_LSB +: 3];
  assign wm_hit = reg_addr >= `PFC_OFF_WM_BASE && reg_addr < `PFC_OFF_STATUS && reg_addr[1:0] == 2'b00;
  assign wm_idx = 3'(reg_addr[5:2] - 4'h4);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `PFC_RST_CTRL;
      prio_ena <= `PFC_RST_PRIO_ENA;
      tx_pause_quanta <= `PFC_RST_PAUSE;
      min_refresh_interval <= `PFC_RST_MIN_REF;
      for (int i = 0; i < `PFC_NUM_PRIO; i++) begin
        wm[i] <= `PFC_RST_WM;
      end
    end else if (reg_wr) begin
      if (wm_hit) begin
        wm[wm_idx] <= reg_wdata[15:0];
      end
      case (reg_addr)
        `PFC_OFF_CTRL: ctrl <= reg_wdata[7:0];
        `PFC_OFF_PRIO_ENA: prio_ena <= reg_wdata[7:0];
        `PFC_OFF_PAUSE: tx_pause_quanta <= reg_wdata[15:0];
        `PFC_OFF_MIN_REF: min_refresh_interval <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Data only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else if (wm_hit) begin
      reg_rdata <= {16'h0000, wm[wm_idx]};
    end else begin
      case (reg_addr)
        `PFC_OFF_CTRL: reg_rdata <= {24'h00_0000, ctrl};
        `PFC_OFF_PRIO_ENA: reg_rdata <= {24'h00_0000, prio_ena};
        `PFC_OFF_PAUSE: reg_rdata <= {16'h0000, tx_pause_quanta};
        `PFC_OFF_MIN_REF: reg_rdata <= {16'h0000, min_refresh_interval};
        `PFC_OFF_STATUS: reg_rdata <= {16'h0000, stop_vec, congestion_vector};
        `PFC_OFF_TX_CNT: reg_rdata <= tx_pause_frame_count;
        `PFC_OFF_RX_CNT: reg_rdata <= rx_unknown_opcode_count;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watermark compare
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      congestion_vector <= 8'h00;
    end else begin
      for (int i = 0; i < `PFC_NUM_PRIO; i++) begin
        congestion_vector[i] <= q_usage[i] > wm[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quanta time base
  // Fractional accumulator in tenths of a bit; at most one tick per clock
  logic [13:0] q_acc;
  logic [13:0] q_sum;
  logic qtick;

  assign q_sum = q_acc + pfc_pkg::pfc_rate_inc(speed);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_acc <= 14'h0000;
      qtick <= 1'b0;
    end else if (q_sum >= QUANTUM) begin
      q_acc <= q_sum - QUANTUM;
      qtick <= 1'b1;
    end else begin
      q_acc <= q_sum;
      qtick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh decision
  logic tg_req;
  logic [7:0] tg_vec;
  logic pdu_done;

  pfc_tx_gen u_tx_gen (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tx_ena(tx_ena),
    .prio_ena(prio_ena),
    .pause_quanta(tx_pause_quanta),
    .min_refresh(min_refresh_interval),
    .congestion_vector(congestion_vector),
    .quanta_tick(qtick),
    .pdu_sent(pdu_done),
    .send_req(tg_req),
    .send_vec(tg_vec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame sender
  logic busy;
  logic [5:0] tx_pos;
  logic [5:0] out_pos;
  logic [7:0] tx_vec;
  pfc_pkg::pfc_quanta_t tx_time;
  logic loading;
  logic advance;
  logic [2:0] tx_slot;
  logic [15:0] tx_word;
  logic [7:0] pdu_byte;

  assign loading = busy && tx_pos != `PFC_PDU_LEN;
  assign advance = !tx_out.valid || tx_ready;
  assign pdu_done = tx_out.valid && tx_out.eop && tx_ready;
  assign tx_slot = 3'((tx_pos - `PFC_TIMES_POS) >> 1);
  assign tx_word = tx_vec[tx_slot] ? tx_time : 16'h0000;

  always_comb begin
    pdu_byte = 8'h00;
    if (tx_pos < `PFC_VEC_POS) begin
      pdu_byte = pfc_pkg::pfc_hdr_byte(tx_pos, SRC_MAC);
    end else if (tx_pos == `PFC_VEC_POS) begin
      pdu_byte = ENA_VEC[15:8];
    end else if (tx_pos < `PFC_TIMES_POS) begin
      pdu_byte = ENA_VEC[7:0];
    end else if (tx_pos < `PFC_TIMES_END) begin
      pdu_byte = tx_pos[0] ? tx_word[7:0] : tx_word[15:8];
    end
  end

  // Vector and pause value frozen at start so a frame never mixes settings
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      tx_pos <= 6'h00;
      out_pos <= 6'h00;
      tx_vec <= 8'h00;
      tx_time <= 16'h0000;
      tx_out <= '0;
    end else begin
      if (tg_req && !busy) begin
        busy <= 1'b1;
        tx_pos <= 6'h00;
        tx_vec <= tg_vec;
        tx_time <= tx_pause_quanta;
      end else if (pdu_done) begin
        busy <= 1'b0;
      end
      if (advance) begin
        if (loading) begin
          tx_out.valid <= 1'b1;
          tx_out.sop <= tx_pos == 6'h00;
          tx_out.eop <= tx_pos == `PFC_PDU_LEN - 6'h01;
          tx_out.data <= pdu_byte;
          out_pos <= tx_pos;
          tx_pos <= tx_pos + 6'h01;
        end else begin
          tx_out <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame receiver
  logic [5:0] rx_pos;
  logic [5:0] rx_at;
  logic rx_match;
  logic rx_hit;
  logic rx_match_n;
  logic [7:0] rx_vec;
  logic [7:0][15:0] rx_times;
  logic [2:0] rx_slot;
  logic frame_ok;
  logic rx_load;
  logic [7:0] rx_stop;

  assign rx_at = rx_in.sop ? 6'h00 : rx_pos;
  assign rx_slot = 3'((rx_at - `PFC_TIMES_POS) >> 1);
  assign rx_hit = (rx_at < 6'h06 || (rx_at > 6'h0b && rx_at < `PFC_VEC_POS)) ?
    rx_in.data == pfc_pkg::pfc_hdr_byte(rx_at, SRC_MAC) : 1'b1;
  assign rx_match_n = (rx_in.sop || rx_match) && rx_hit;
  assign frame_ok = rx_in.valid && rx_in.eop && rx_match_n && rx_at >= `PFC_PDU_LEN - 6'h01;
  assign rx_load = frame_ok && rx_ena;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_pos <= 6'h00;
      rx_match <= 1'b0;
      rx_vec <= 8'h00;
      rx_times <= '0;
    end else if (rx_in.valid) begin
      rx_pos <= (rx_at == 6'h3f) ? 6'h3f : rx_at + 6'h01;
      rx_match <= rx_match_n;
      if (rx_at == `PFC_VEC_POS + 6'h01) begin
        rx_vec <= rx_in.data;
      end
      if (rx_at >= `PFC_TIMES_POS && rx_at < `PFC_TIMES_END) begin
        if (rx_at[0]) begin
          rx_times[rx_slot][7:0] <= rx_in.data;
        end else begin
          rx_times[rx_slot][15:8] <= rx_in.data;
        end
      end
    end
  end

  pfc_rx_pause u_rx_pause (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(rx_load),
    .load_vec(rx_vec),
    .load_times(rx_times),
    .quanta_tick(qtick),
    .stop(rx_stop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Stop record and egress hold-back
  // Not gated by any setting: the hold-back follows the counters alone
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_vec <= 8'h00;
      egress_allow <= 8'h00;
    end else begin
      stop_vec <= rx_stop;
      egress_allow <= egress_req & ~rx_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Statistics
  // Frozen while the port module keeps its own counts
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_pause_frame_count <= 32'h0000_0000;
    end else if (pdu_done && !local_stats) begin
      tx_pause_frame_count <= tx_pause_frame_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_unknown_opcode_count <= 32'h0000_0000;
    end else if (frame_ok && !local_stats) begin
      rx_unknown_opcode_count <= rx_unknown_opcode_count + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_wm_cong: assert property (@(posedge sys_clk) disable iff (sys_rst)
    q_usage[0] > wm[0] |=> congestion_vector[0])
    else $error("watermark crossing not flagged");
  chk_dst_first: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tx_out.valid && tx_out.sop |-> tx_out.data == 8'h01 && out_pos == 6'h00)
    else $error("frame does not open with the reserved address");
  chk_ena_vec_lo: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tx_out.valid && out_pos == 6'h11 |-> tx_out.data == 8'hff)
    else $error("enable vector low byte wrong");
  chk_dis_time_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tx_out.valid && out_pos >= 6'h12 && out_pos < 6'h22 && !tx_vec[3'((out_pos - 6'h12) >> 1)]
    |-> tx_out.data == 8'h00)
    else $error("idle class carries a pause time");
  chk_tx_count: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pdu_done && !local_stats |=> tx_pause_frame_count == $past(tx_pause_frame_count) + 32'h0000_0001)
    else $error("sent frame not counted");
  chk_rx_count: assert property (@(posedge sys_clk) disable iff (sys_rst)
    frame_ok && !local_stats |=> rx_unknown_opcode_count == $past(rx_unknown_opcode_count) + 32'h0000_0001)
    else $error("received frame not counted");
  chk_stop_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rx_load && rx_vec[0] && rx_times[0] > 16'h0001 |-> ##2 stop_vec[0])
    else $error("stop not raised after pause frame");
  chk_egress_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (egress_allow & stop_vec) == 8'h00)
    else $error("stopped queue allowed to send");
  chk_tick_10g: assert property (@(posedge sys_clk) disable iff (sys_rst)
    speed == pfc_pkg::PFC_SPD_10G && $past(speed) == pfc_pkg::PFC_SPD_10G && !qtick |=> qtick)
    else $error("quanta rate too slow at top speed");
endmodule : pfc_top

// ### verif/pfc_link_partner.sv
module pfc_link_partner (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Frames from the device
  input wire pfc_pkg::pfc_byte_s tx_out,
  output logic tx_ready,
  // Frames to the device
  output pfc_pkg::pfc_byte_s rx_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] frm [60];
  int idx;
  int frames;
  logic [1:0] beat;

  initial rx_in = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Stall one beat in four, so the sender must hold its byte
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      beat <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      beat <= beat + 2'h1;
      tx_ready <= (beat != 2'h2);
    end
  end

  // Keep the last whole frame
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx <= 0;
      frames <= 0;
    end else if (tx_out.valid && tx_ready) begin
      frm[tx_out.sop ? 0 : idx] <= tx_out.data;
      idx <= tx_out.sop ? 1 : idx + 1;
      if (tx_out.eop) frames <= frames + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Class pause frame, times in quanta, class 0 first
  task automatic send_pfc(input logic [7:0] vec, input logic [7:0][15:0] t);
    logic [479:0] f;
    f = {48'h0180_c200_0001, 48'h0000_0000_0002, 16'h8808, 16'h0101, 8'h00, vec, {<<16{t}}, 208'h0};
    for (int i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      rx_in <= {1'b1, i == 0, i == 59, f[479 - 8 * i -: 8]};
    end
    // Idle line must not look like the last byte
    @(posedge sys_clk);
    rx_in <= {3'b000, ~f[7:0]};
  endtask : send_pfc
endmodule : pfc_link_partner

// ### verif/priority_flow_control_tb.sv
module priority_flow_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0][15:0] q_usage;
  logic [7:0] egress_req;
  logic [7:0] egress_allow;
  logic [7:0] stop_vec;
  pfc_pkg::pfc_byte_s tx_out;
  pfc_pkg::pfc_byte_s rx_in;
  logic tx_ready;
  logic [191:0] e;
  int failures;
  int compares;
  int k;

  always #20 sys_clk = ~sys_clk;

  pfc_top u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .q_usage(q_usage), .egress_req(egress_req),
    .egress_allow(egress_allow), .stop_vec(stop_vec), .tx_out(tx_out), .tx_ready(tx_ready), .rx_in(rx_in));
  pfc_link_partner u_peer (.sys_clk(sys_clk), .sys_rst(sys_rst), .tx_out(tx_out), .tx_ready(tx_ready),
    .rx_in(rx_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] x);
    compares++;
    if (got !== x) begin
      failures++;
      $display("unexpected %0t got %h expected %h", $time, got, x);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, x);
  endtask : rdc

  // Bounded wait for the far side to have taken n frames
  task automatic wait_frames(input int n);
    for (int i = 0; i < 2000 && u_peer.frames < n; i++) @(posedge sys_clk);
    if (u_peer.frames < n) begin
      failures++;
      $display("unexpected %0t no pause frame", $time);
      results();
    end
  endtask : wait_frames

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    q_usage = '0;
    egress_req = 8'hff;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h04, 32'h0000_00ff);
    rdc(8'h08, 32'h0000_ffff);
    rdc(8'h0c, 32'h0000_0040);
    rdc(8'h2c, 32'h0000_0100);
    rdc(8'hfc, 32'h0000_0000);
    wr(8'h04, 32'h0000_00fd);
    wr(8'h08, 32'h0000_0020);
    wr(8'h00, 32'h0000_0041);
    // Class 2 sits exactly on its mark, so stays uncongested
    @(posedge sys_clk);
    q_usage <= {96'h0, 16'h0100, 16'h0101, 16'h0101};
    rdc(8'h30, 32'h0000_0003);
    wait_frames(1);
    e = {48'h0180_c200_0001, 48'h0, 32'h8808_0101, 16'h00ff, 16'h0020, 32'h0};
    for (k = 0; k < 24; k++) chk({24'h0, u_peer.frm[k]}, {24'h0, e[191 - 8 * k -: 8]});
    rdc(8'h34, 32'h0000_0001);
    wait_frames(2);
    q_usage <= '0;
    repeat (200) @(posedge sys_clk);
    chk(32'(u_peer.frames), 32'h0000_0002);
    // Class 2 joins mid-timer; its frame must come long before the half-time point
    wr(8'h08, 32'h0000_0400);
    wr(8'h0c, 32'h0000_0004);
    q_usage <= {112'h0, 16'h0101};
    wait_frames(3);
    q_usage <= {96'h0, 16'h0101, 16'h0000, 16'h0101};
    repeat (150) @(posedge sys_clk);
    chk(32'(u_peer.frames), 32'h0000_0004);
    chk({24'h0, u_peer.frm[22]}, 32'h0000_0004);
    q_usage <= '0;
    wr(8'h00, 32'h0000_0043);
    egress_req <= 8'h7f;
    // Class 1 time is outside the enable vector and must be ignored
    u_peer.send_pfc(8'h05, {80'h0, 16'h0030, 16'h0050, 16'h0040});
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({24'h0, stop_vec}, 32'h0000_0005);
    chk({24'h0, egress_allow}, 32'h0000_007a);
    repeat (40) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({24'h0, stop_vec}, 32'h0000_0005);
    for (k = 0; k < 300 && stop_vec !== 8'h00; k++) @(posedge sys_clk);
    if (k == 300) begin
      failures++;
      $display("unexpected %0t stop never released", $time);
      results();
    end
    @(negedge sys_clk);
    chk({24'h0, egress_allow}, 32'h0000_007f);
    rdc(8'h38, 32'h0000_0001);
    // Reaction off while sending stays on
    wr(8'h00, 32'h0000_0041);
    u_peer.send_pfc(8'hff, {8{16'h0040}});
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({24'h0, stop_vec}, 32'h0000_0000);
    rdc(8'h38, 32'h0000_0002);
    // Counts frozen while the port module keeps them
    wr(8'h00, 32'h0000_0045);
    u_peer.send_pfc(8'hff, {8{16'h0040}});
    rdc(8'h38, 32'h0000_0002);
    results();
  end
endmodule : priority_flow_control_tb
